// File: hw/asu_buf_if.sv
// asu_buf_if: valid/ready carrier between the channel and its buffer
`timescale 1ns/1ps
interface asu_buf_if;
  import asu_pkg::*;
  logic              in_valid;
  logic              in_ready;
  logic [ASU_DW-1:0] in_data;
  logic              out_valid;
  logic              out_ready;
  logic [ASU_DW-1:0] out_data;
  modport store (input in_valid, in_data, out_ready,
                 output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface

// File: hw/asu_fifo2.sv
// asu_fifo2: two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module asu_fifo2
  import asu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  asu_buf_if.store b
);
  typedef struct packed {
    logic [ASU_DW-1:0] d0;
    logic [ASU_DW-1:0] d1;
    logic [1:0]        cnt;
  } asu_fifo_t;

  asu_fifo_t s_reg;
  asu_fifo_t s_next;
  logic      push;
  logic      pop;

  assign b.in_ready  = (s_reg.cnt != ASU_FIFO_DEPTH);
  assign b.out_valid = (s_reg.cnt != 2'h0);
  assign b.out_data  = s_reg.d0;

  always_comb begin
    push   = b.in_valid & b.in_ready;
    pop    = b.out_ready & b.out_valid;
    s_next = s_reg;
    unique case ({push, pop})
      2'b10: begin
        if (s_reg.cnt == 2'h0) s_next.d0 = b.in_data;
        else s_next.d1 = b.in_data;
        s_next.cnt = s_reg.cnt + 2'h1;
      end
      2'b01: begin
        s_next.d0  = s_reg.d1;
        s_next.cnt = s_reg.cnt - 2'h1;
      end
      // both only possible with one entry held
      2'b11: s_next.d0 = b.in_data;
      2'b00: s_next = s_reg;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) s_reg <= '0;
    else s_reg <= s_next;
  end
endmodule

// File: hw/asu_pkg.sv
// asu_pkg: constants and types shared by the serial channel files
package asu_pkg;
  localparam int          ASU_DW         = 9;
  // sixteen ticks of the bit clock make one bit on the line
  localparam logic [3:0]  ASU_OVS_LAST   = 4'hF;
  localparam logic [3:0]  ASU_OVS_MID    = 4'h7;
  localparam logic [3:0]  ASU_OVS_HALF   = 4'h7;
  localparam logic [2:0]  ASU_DIV8_LAST  = 3'h7;
  localparam logic [4:0]  ASU_DIV32_LAST = 5'h1F;
  localparam logic [1:0]  ASU_SRC_F1     = 2'h0;
  localparam logic [1:0]  ASU_SRC_F8     = 2'h1;
  localparam logic [1:0]  ASU_SRC_F32    = 2'h2;
  localparam logic [1:0]  ASU_LEN7       = 2'h0;
  localparam logic [1:0]  ASU_LEN8       = 2'h1;
  localparam logic [1:0]  ASU_LEN9       = 2'h2;
  localparam logic [3:0]  ASU_NB7        = 4'h7;
  localparam logic [3:0]  ASU_NB8        = 4'h8;
  localparam logic [3:0]  ASU_NB9        = 4'h9;
  localparam logic [8:0]  ASU_MASK9      = 9'h1FF;
  localparam logic [1:0]  ASU_FIFO_DEPTH = 2'h2;

  typedef enum logic [2:0] {
    ASU_TX_IDLE  = 3'b000,
    ASU_TX_START = 3'b001,
    ASU_TX_DATA  = 3'b010,
    ASU_TX_PAR   = 3'b011,
    ASU_TX_STOP  = 3'b100,
    ASU_TX_HOLD  = 3'b101
  } asu_tx_t;

  typedef enum logic [2:0] {
    ASU_RX_IDLE  = 3'b000,
    ASU_RX_START = 3'b001,
    ASU_RX_DATA  = 3'b010,
    ASU_RX_PAR   = 3'b011,
    ASU_RX_STOP  = 3'b100
  } asu_rx_t;
endpackage

// File: hw/asu_uart.sv
// asu_uart: asynchronous serial channel with smart-card options
`timescale 1ns/1ps
// Functional notes
// - from mode select until transfer, output idles high or floats if open drain
// - external transfer clock used only when selected and not smart-card channel
// - flow pin unused when disabled, else clear-to-send input or request output
// - sleep mode keeps only characters whose data MSB is one
// - data logic select inverts data on buffer write and buffer read
// - polarity reversal inverts every line level in and out, framing bits included
// - compare output and input pin levels at mid-bit of each sent bit, flag any mismatch
// - bit clock is prescaled source over sixteen times rate setting plus one
// - send only with transmit enabled and data waiting in the buffer
// - receive only with receive enabled and a start bit detected
// - transmit request on shift end or buffer move, receive on buffer load
// - overrun overwrites the receive buffer without a new receive request
// - with error output enabled a parity error drives the output low
// - sender reads the input level at transmit completion to spot far parity error
// - smart-card channel has no sleep filtering
// - frame is start, seven to nine data bits, optional parity, one or two stops
// - framing error on a missing stop bit, sum flag on any error
// - error output enabled delays transmit completion by half a bit
module asu_uart
  import asu_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       serial_in_pin,
  output wire logic       serial_out_pin,
  output wire logic       serial_out_oe_n,
  input  wire logic       transfer_clock_pin,
  input  wire logic       flow_control_in,
  output wire logic       flow_control_out,
  output wire logic       flow_control_oe_n,
  input  wire logic       sim_mode,
  input  wire logic       tx_enable,
  input  wire logic       rx_enable,
  input  wire logic       clk_ext_sel,
  input  wire logic [1:0] clk_src_sel,
  input  wire logic [7:0] brg_n,
  input  wire logic [1:0] data_len,
  input  wire logic       parity_en,
  input  wire logic       parity_even,
  input  wire logic       stop2,
  input  wire logic       msb_first,
  input  wire logic       flow_disable,
  input  wire logic       flow_rts_sel,
  input  wire logic       sleep_sel,
  input  wire logic       data_inv,
  input  wire logic       pol_inv,
  input  wire logic       open_drain,
  input  wire logic       err_sig_en,
  input  wire logic       tx_irq_on_done,
  input  wire logic       tx_wr_valid,
  input  wire logic [8:0] tx_wr_data,
  output wire logic       tx_wr_ready,
  output wire logic       tx_buf_empty,
  output wire logic [8:0] rx_data,
  output wire logic       rx_full,
  input  wire logic       rx_read,
  output wire logic       rx_overrun,
  output wire logic       rx_framing_err,
  output wire logic       rx_parity_err,
  output wire logic       rx_err_sum,
  output wire logic       tx_irq,
  output wire logic       rx_irq,
  output wire logic       collision_irq,
  output wire logic       far_parity_nak
);
  typedef struct packed {
    logic [4:0] pre;
    logic [7:0] brg;
    logic       tick;
    logic       ext_prev;
    asu_tx_t    tx_st;
    logic [3:0] tx_ovs;
    logic [3:0] tx_idx;
    logic       tx_stop2;
    logic [8:0] tx_sh;
    asu_rx_t    rx_st;
    logic [3:0] rx_ovs;
    logic [3:0] rx_idx;
    logic       rx_stop2;
    logic       rx_prev;
    logic [8:0] rx_sh;
    logic       rx_pe;
    logic       rx_fe;
    logic [8:0] rx_buf;
    logic [8:0] rx_out;
    logic       rx_full;
    logic       ovr;
    logic       fer;
    logic       per;
    logic       err_act;
    logic [3:0] err_cnt;
    logic       out;
    logic       rts_n;
    logic       tx_irq;
    logic       rx_irq;
    logic       col_irq;
    logic       nak;
  } asu_state_t;

  // line idles high and request-to-send idles deasserted
  localparam asu_state_t ASU_RST = '{out: 1'b1, rx_prev: 1'b1,
                                     rts_n: 1'b1, tx_st: ASU_TX_IDLE,
                                     rx_st: ASU_RX_IDLE, default: '0};

  asu_state_t s_reg;
  asu_state_t s_next;
  asu_buf_if  txb ();
  logic [3:0] nb;
  logic [8:0] mask;
  logic [8:0] inv_mask;
  logic       tx_pop;

  // ****************************************
  // character format and transmit buffer
  // ****************************************
  always_comb begin
    unique case (data_len)
      ASU_LEN7: nb = ASU_NB7;
      ASU_LEN9: nb = ASU_NB9;
      default:  nb = ASU_NB8;
    endcase
  end
  assign mask     = ASU_MASK9 >> (ASU_NB9 - nb);
  assign inv_mask = data_inv ? mask : 9'h000;

  assign txb.in_valid  = tx_wr_valid;
  assign txb.in_data   = tx_wr_data ^ inv_mask;
  assign txb.out_ready = tx_pop;
  assign tx_wr_ready   = txb.in_ready;
  assign tx_buf_empty  = !txb.out_valid;

  asu_fifo2 u_txbuf (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .b       (txb)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic       ext;
    logic       src_tick;
    logic       cts_ok;
    logic       rx_line;
    logic       line;
    logic       done;
    logic       fe_now;
    logic [3:0] sel_tx;
    logic [3:0] sel_rx;
    ext      = 1'b0;
    src_tick = 1'b0;
    cts_ok   = 1'b0;
    rx_line  = 1'b0;
    line     = 1'b1;
    done     = 1'b0;
    fe_now   = 1'b0;
    sel_tx   = '0;
    sel_rx   = '0;
    tx_pop   = 1'b0;
    s_next   = s_reg;
    s_next.tx_irq  = 1'b0;
    s_next.rx_irq  = 1'b0;
    s_next.col_irq = 1'b0;

    // bit clock: source over sixteen times (n+1)
    ext = clk_ext_sel & !sim_mode;
    s_next.pre      = s_reg.pre + 5'h01;
    s_next.ext_prev = transfer_clock_pin;
    if (ext) begin
      src_tick = transfer_clock_pin & !s_reg.ext_prev;
    end else begin
      unique case (clk_src_sel)
        ASU_SRC_F8:  src_tick = (s_reg.pre[2:0] == ASU_DIV8_LAST);
        ASU_SRC_F32: src_tick = (s_reg.pre == ASU_DIV32_LAST);
        default:     src_tick = 1'b1;
      endcase
    end
    s_next.tick = 1'b0;
    if (src_tick) begin
      if (s_reg.brg == 8'h00) begin
        s_next.tick = 1'b1;
        s_next.brg  = brg_n;
      end else begin
        s_next.brg = s_reg.brg - 8'h01;
      end
    end

    // ****************************************
    // transmitter
    // ****************************************
    cts_ok = flow_disable | flow_rts_sel | !flow_control_in;
    if (msb_first) sel_tx = nb - 4'h1 - s_reg.tx_idx;
    else sel_tx = s_reg.tx_idx;
    if (s_reg.tx_st == ASU_TX_IDLE) begin
      // start needs enable and a waiting word
      tx_pop = tx_enable & txb.out_valid & cts_ok;
      if (tx_pop) begin
        s_next.tx_st    = ASU_TX_START;
        s_next.tx_ovs   = '0;
        s_next.tx_sh    = txb.out_data;
        s_next.tx_stop2 = 1'b0;
        s_next.tx_irq   = !tx_irq_on_done;
      end
    end else if (s_reg.tick) begin
      s_next.tx_ovs = s_reg.tx_ovs + 4'h1;
      // collision check against the pin levels
      if (s_reg.tx_ovs == ASU_OVS_MID) begin
        s_next.col_irq = (s_reg.out != serial_in_pin);
      end
      if (s_reg.tx_st == ASU_TX_HOLD) begin
        if (s_reg.tx_ovs == ASU_OVS_HALF) done = 1'b1;
      end else if (s_reg.tx_ovs == ASU_OVS_LAST) begin
        unique case (s_reg.tx_st)
          ASU_TX_START: begin
            s_next.tx_st  = ASU_TX_DATA;
            s_next.tx_idx = '0;
          end
          ASU_TX_DATA: begin
            s_next.tx_idx = s_reg.tx_idx + 4'h1;
            if (s_reg.tx_idx == nb - 4'h1) begin
              s_next.tx_st = parity_en ? ASU_TX_PAR : ASU_TX_STOP;
            end
          end
          ASU_TX_PAR: s_next.tx_st = ASU_TX_STOP;
          ASU_TX_STOP: begin
            if (stop2 && !s_reg.tx_stop2) begin
              s_next.tx_stop2 = 1'b1;
            end else if (err_sig_en) begin
              s_next.tx_st = ASU_TX_HOLD;
            end else begin
              done = 1'b1;
            end
          end
          default: s_next.tx_st = ASU_TX_IDLE;
        endcase
      end
    end
    if (done) begin
      s_next.tx_st  = ASU_TX_IDLE;
      s_next.tx_irq = tx_irq_on_done;
      // far end pulls the line low on a parity fault
      s_next.nak = !(serial_in_pin ^ pol_inv);
    end

    // ****************************************
    // receiver
    // ****************************************
    rx_line = serial_in_pin ^ pol_inv;
    s_next.rx_prev = rx_line;
    if (msb_first) sel_rx = nb - 4'h1 - s_reg.rx_idx;
    else sel_rx = s_reg.rx_idx;
    if (s_reg.rx_st == ASU_RX_IDLE) begin
      // own error pulse must not look like a start bit
      if (rx_enable && s_reg.rx_prev && !rx_line && !s_reg.err_act) begin
        s_next.rx_st  = ASU_RX_START;
        s_next.rx_ovs = '0;
      end
    end else if (s_reg.tick) begin
      s_next.rx_ovs = s_reg.rx_ovs + 4'h1;
      unique case (s_reg.rx_st)
        ASU_RX_START: begin
          if (s_reg.rx_ovs == ASU_OVS_MID) begin
            s_next.rx_ovs   = '0;
            s_next.rx_idx   = '0;
            s_next.rx_sh    = '0;
            s_next.rx_pe    = 1'b0;
            s_next.rx_fe    = 1'b0;
            s_next.rx_stop2 = 1'b0;
            s_next.rx_st    = rx_line ? ASU_RX_IDLE : ASU_RX_DATA;
          end
        end
        ASU_RX_DATA: begin
          if (s_reg.rx_ovs == ASU_OVS_LAST) begin
            s_next.rx_sh[sel_rx] = rx_line;
            s_next.rx_idx = s_reg.rx_idx + 4'h1;
            if (s_reg.rx_idx == nb - 4'h1) begin
              s_next.rx_st = parity_en ? ASU_RX_PAR : ASU_RX_STOP;
            end
          end
        end
        ASU_RX_PAR: begin
          if (s_reg.rx_ovs == ASU_OVS_LAST) begin
            s_next.rx_pe = rx_line
                         != (^(s_reg.rx_sh & mask) ^ !parity_even);
            s_next.rx_st = ASU_RX_STOP;
          end
        end
        ASU_RX_STOP: begin
          if (s_reg.rx_ovs == ASU_OVS_LAST) begin
            fe_now = s_reg.rx_fe | !rx_line;
            s_next.rx_fe = fe_now;
            if (stop2 && !s_reg.rx_stop2) begin
              s_next.rx_stop2 = 1'b1;
            end else begin
              s_next.rx_st = ASU_RX_IDLE;
              if (s_reg.rx_pe && err_sig_en) begin
                s_next.err_act = 1'b1;
                s_next.err_cnt = '0;
              end
              // sleep filter is absent on the smart-card channel
              if (!(sleep_sel && !sim_mode)
                  || s_reg.rx_sh[nb - 4'h1]) begin
                s_next.rx_buf = s_reg.rx_sh & mask;
                s_next.fer    = fe_now;
                s_next.per    = s_reg.rx_pe;
                if (s_reg.rx_full && !rx_read) begin
                  s_next.ovr = 1'b1;
                end else begin
                  s_next.rx_irq = 1'b1;
                end
                s_next.rx_full = 1'b1;
              end
            end
          end
        end
        default: s_next.rx_st = ASU_RX_IDLE;
      endcase
    end
    // a read clears, but a new character in the same cycle wins
    if (rx_read && !(s_next.rx_full && !s_reg.rx_full)
        && s_next.rx_irq == 1'b0 && !(s_next.ovr && !s_reg.ovr)) begin
      s_next.rx_full = 1'b0;
      s_next.ovr     = 1'b0;
    end
    if (s_reg.err_act && s_reg.tick) begin
      s_next.err_cnt = s_reg.err_cnt + 4'h1;
      if (s_reg.err_cnt == ASU_OVS_LAST) s_next.err_act = 1'b0;
    end
    s_next.rx_out = s_next.rx_buf ^ inv_mask;
    s_next.rts_n  = !(rx_enable && !s_next.rx_full);

    // ****************************************
    // pin level
    // ****************************************
    unique case (s_next.tx_st)
      ASU_TX_START: line = 1'b0;
      ASU_TX_DATA:  line = s_next.tx_sh[sel_tx];
      ASU_TX_PAR:   line = ^(s_next.tx_sh & mask) ^ !parity_even;
      default:      line = 1'b1;
    endcase
    if (s_next.tx_st == ASU_TX_DATA && s_next.tx_idx != s_reg.tx_idx) begin
      line = s_next.tx_sh[msb_first ? nb - 4'h1 - s_next.tx_idx
                                    : s_next.tx_idx];
    end
    if (s_next.err_act) line = 1'b0;
    s_next.out = line ^ pol_inv;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) s_reg <= ASU_RST;
    else s_reg <= s_next;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign serial_out_pin    = s_reg.out;
  // open drain floats the pin whenever it should read high
  assign serial_out_oe_n   = open_drain & s_reg.out;
  assign flow_control_out  = s_reg.rts_n;
  assign flow_control_oe_n = flow_disable | !flow_rts_sel;
  assign rx_data           = s_reg.rx_out;
  assign rx_full           = s_reg.rx_full;
  assign rx_overrun        = s_reg.ovr;
  assign rx_framing_err    = s_reg.fer;
  assign rx_parity_err     = s_reg.per;
  assign rx_err_sum        = s_reg.ovr | s_reg.fer | s_reg.per;
  assign tx_irq            = s_reg.tx_irq;
  assign rx_irq            = s_reg.rx_irq;
  assign collision_irq     = s_reg.col_irq;
  assign far_parity_nak    = s_reg.nak;

  // ****************************************
  // checks
  // ****************************************
  idle_high_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_reg.tx_st == ASU_TX_IDLE && !s_reg.err_act && $past(rst_n))
    |-> serial_out_pin == !$past(pol_inv))
    else $error("idle line not high");

  start_level_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_reg.tx_st == ASU_TX_START && !s_reg.err_act && $past(rst_n))
    |-> serial_out_pin == $past(pol_inv))
    else $error("start bit level wrong");

  tx_gate_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_reg.tx_st == ASU_TX_IDLE && (!tx_enable || tx_buf_empty))
    |=> s_reg.tx_st == ASU_TX_IDLE)
    else $error("transmit started without enable or data");

  rx_gate_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_reg.rx_st == ASU_RX_IDLE && !rx_enable)
    |=> s_reg.rx_st == ASU_RX_IDLE)
    else $error("receive started while disabled");

  overrun_quiet_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(s_reg.ovr) |-> !s_reg.rx_irq && s_reg.rx_full)
    else $error("overrun raised a receive request");

  err_low_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_reg.err_act && $past(rst_n))
    |-> serial_out_pin == $past(pol_inv))
    else $error("error signal not driven low");

  frame_err_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(s_reg.fer) |-> s_reg.rx_full && rx_err_sum)
    else $error("framing error without character");

  hold_delay_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_reg.tx_st == ASU_TX_HOLD) |-> !tx_irq)
    else $error("completion before half bit delay");

  sleep_filter_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_reg.rx_irq && $past(sleep_sel) && !$past(sim_mode)
     && $stable(data_len))
    |-> s_reg.rx_buf[nb - 4'h1])
    else $error("sleep mode kept a zero MSB character");
endmodule

// File: sim/asu_far.sv
// asu_far: far serial party that sends and captures frames on the line
`timescale 1ns/1ps
module asu_far #(
  parameter int BIT = 16
) (
  input  wire logic clk_sys,
  input  wire logic rx_line,
  output logic      tx_line
);
  // a released line rests at the pull-up level
  initial tx_line = 1'b1;
  // frame bits leave first bit first, one bit time each
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      tx_line = f[i];
      repeat (BIT-1) @(negedge clk_sys);
    end
    @(negedge clk_sys);
    tx_line = 1'b1;
  endtask
  // returns at mid stop bit so a back-to-back frame is not missed
  task automatic grab(input int n, output logic [11:0] f);
    bit seen;
    seen = 1'b0;
    f = '0;
    for (int t = 0; t < 600 && !seen; t++) begin
      // falling edge keeps clear of the edge that launches the line
      @(negedge clk_sys);
      seen = (rx_line == 1'b0);
    end
    repeat (BIT/2) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      if (i > 0)
        repeat (BIT) @(negedge clk_sys);
      f[i] = rx_line;
    end
  endtask
endmodule

// File: sim/asu_uart_tb.sv
// asu_uart_tb: self-checking bench for the serial channel
`timescale 1ns/1ps
module asu_uart_tb;
  import asu_pkg::*;
  logic clk_sys, rst_n, transfer_clock_pin, flow_control_in, sim_mode;
  logic tx_enable, rx_enable, clk_ext_sel, parity_en, parity_even, stop2;
  logic msb_first, flow_disable, flow_rts_sel, sleep_sel, data_inv;
  logic pol_inv, open_drain, err_sig_en, tx_irq_on_done, tx_wr_valid;
  logic       rx_read;
  logic [1:0] clk_src_sel, data_len;
  logic [7:0] brg_n;
  logic [8:0] tx_wr_data;
  wire logic  serial_in_pin, serial_out_pin, serial_out_oe_n;
  wire logic  flow_control_out, flow_control_oe_n, tx_wr_ready;
  wire logic  tx_buf_empty, rx_full, rx_overrun, rx_framing_err;
  wire logic  rx_parity_err, rx_err_sum, tx_irq, rx_irq;
  wire logic  collision_irq, far_parity_nak;
  wire logic [8:0] rx_data;
  int n_fail, compares, cyc, n_tx, n_rx, n_col;

  asu_uart i_dut (.clk_sys, .rst_n, .serial_in_pin, .serial_out_pin,
    .serial_out_oe_n, .transfer_clock_pin, .flow_control_in,
    .flow_control_out, .flow_control_oe_n, .sim_mode, .tx_enable,
    .rx_enable, .clk_ext_sel, .clk_src_sel, .brg_n, .data_len, .parity_en,
    .parity_even, .stop2, .msb_first, .flow_disable, .flow_rts_sel,
    .sleep_sel, .data_inv, .pol_inv, .open_drain, .err_sig_en,
    .tx_irq_on_done, .tx_wr_valid, .tx_wr_data, .tx_wr_ready, .tx_buf_empty,
    .rx_data, .rx_full, .rx_read, .rx_overrun, .rx_framing_err,
    .rx_parity_err, .rx_err_sum, .tx_irq, .rx_irq, .collision_irq,
    .far_parity_nak);
  // the far party sees the pull-up while our output floats
  asu_far far (.clk_sys, .tx_line(serial_in_pin),
    .rx_line(serial_out_oe_n ? 1'b1 : serial_out_pin));

  // ****************************************
  // clock, pulse counters, watchdog
  // ****************************************
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    n_tx <= n_tx + int'(tx_irq === 1'b1);
    n_rx <= n_rx + int'(rx_irq === 1'b1);
    n_col <= n_col + int'(collision_irq === 1'b1);
    if (cyc == 10000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] fr(input logic [7:0] d, input logic p);
    return {2'b01, p, d, 1'b0};
  endfunction
  task automatic put(input logic [8:0] d);
    @(negedge clk_sys);
    tx_wr_valid = 1'b1;
    tx_wr_data = d;
    do @(posedge clk_sys); while (tx_wr_ready !== 1'b1);
    @(negedge clk_sys);
    tx_wr_valid = 1'b0;
  endtask
  task automatic rd();
    @(negedge clk_sys);
    rx_read = 1'b1;
    @(negedge clk_sys);
    rx_read = 1'b0;
  endtask
  task automatic rx_frame(input logic [11:0] f, input int n);
    far.send(f, n);
    repeat (3) @(negedge clk_sys);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_idle();
    chk(serial_out_pin, 1);
    chk(serial_out_oe_n, 0);
    open_drain = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(serial_out_oe_n, 1);
    open_drain = 1'b0;
    chk(flow_control_oe_n, 1);
    $display("t_idle done");
  endtask
  task automatic t_tx();
    logic [11:0] f, g;
    put(9'h0A5);
    put(9'h05A);
    chk(tx_wr_ready, 0);
    repeat (40) @(negedge clk_sys);
    chk(serial_out_pin, 1);
    tx_enable = 1'b0;
    flow_control_in = 1'b0;
    repeat (40) @(negedge clk_sys);
    chk(serial_out_pin, 1);
    chk(tx_buf_empty, 0);
    fork
      begin
        far.grab(10, f);
        far.grab(10, g);
      end
      tx_enable = 1'b1;
    join
    repeat (20) @(negedge clk_sys);
    // no parity: ten bits captured, stop bit last
    chk(f, fr(8'hA5, 1'b1) & 12'h3FF);
    chk(g, fr(8'h5A, 1'b1) & 12'h3FF);
    chk(n_tx, 2);
    chk(n_col, 10);
    chk(tx_buf_empty, 1);
    chk(far_parity_nak, 0);
    // far end holds the line low across completion, half-bit hold on
    err_sig_en = 1'b1;
    fork
      far.send(12'h000, 11);
      put(9'h0FF);
    join
    chk(far_parity_nak, 1);
    err_sig_en = 1'b0;
    $display("t_tx done");
  endtask
  task automatic t_rx();
    parity_en = 1'b1;
    rx_frame(fr(8'h3C, 1'b0), 11);
    chk(rx_full, 0);
    rx_enable = 1'b1;
    flow_rts_sel = 1'b1;
    n_rx = 0;
    rx_frame(fr(8'h3C, 1'b0), 11);
    chk(rx_data, 9'h03C);
    chk(n_rx, 1);
    chk(rx_err_sum, 0);
    chk(flow_control_out, 1);
    chk(flow_control_oe_n, 0);
    rd();
    err_sig_en = 1'b1;
    far.send(fr(8'h3C, 1'b1), 11);
    chk(serial_out_pin, 0);
    chk(rx_parity_err, 1);
    chk(rx_err_sum, 1);
    err_sig_en = 1'b0;
    repeat (20) @(negedge clk_sys);
    n_rx = 0;
    rx_frame(fr(8'h55, 1'b0), 11);
    chk(rx_overrun, 1);
    chk(rx_data, 9'h055);
    chk(n_rx, 0);
    rd();
    rx_frame(fr(8'h3C, 1'b0) & 12'h3FF, 11);
    chk(rx_framing_err, 1);
    rd();
    repeat (20) @(negedge clk_sys);
    $display("t_rx done");
  endtask
  task automatic t_sleep();
    parity_en = 1'b0;
    sleep_sel = 1'b1;
    rx_frame(fr(8'h12, 1'b1), 10);
    chk(rx_full, 0);
    rx_frame(fr(8'h92, 1'b1), 10);
    chk(rx_data, 9'h092);
    rd();
    // smart-card setup: eight bits, one stop, no flow control
    sim_mode = 1'b1;
    flow_disable = 1'b1;
    rx_frame(fr(8'h12, 1'b1), 10);
    chk(rx_data, 9'h012);
    data_inv = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(rx_data, 9'h0ED);
    rd();
    // inverse convention: odd parity, inverted data, msb first
    {parity_en, parity_even, msb_first} = 3'h5;
    rx_frame(fr(8'h80, 1'b0), 11);
    chk(rx_data, 9'h0FE);
    chk(rx_parity_err, 0);
    pol_inv = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(serial_out_pin, 0);
    $display("t_sleep done");
  endtask

  task automatic finish_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    {clk_sys, rst_n, transfer_clock_pin, sim_mode, tx_enable} = '0;
    {rx_enable, clk_ext_sel, parity_en, stop2, msb_first} = '0;
    {flow_disable, flow_rts_sel, sleep_sel, data_inv, pol_inv} = '0;
    {open_drain, err_sig_en, tx_wr_valid, rx_read, brg_n} = '0;
    {n_fail, compares, cyc, n_tx, n_rx, n_col} = '0;
    tx_wr_data = 9'h000;
    parity_even = 1'b1;
    flow_control_in = 1'b1;
    tx_enable = 1'b1;
    tx_irq_on_done = 1'b1;
    clk_src_sel = ASU_SRC_F1;
    data_len = ASU_LEN8;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    t_idle();
    t_tx();
    t_rx();
    t_sleep();
    finish_test();
  end
endmodule
